// ==== core/eti_trigger_input.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Per-line enable; disabled lines ignore triggers
// [RULE2] Enable state of each line readable
// [RULE3] One response action held per line
// [RULE4] On/off response drives selected channel outputs
// [RULE5] Toggle response inverts selected channel outputs
// [RULE6] Supply response sets channels to supply mode
// [RULE7] Load responses set load CV/CC/CR mode
// [RULE8] Independent response sets pair independent, supply
// [RULE9] Series response sets pair series tracking
// [RULE10] Parallel response sets pair parallel tracking
// [RULE11] Controller selects both channels in supply first
// [RULE12] Response of each line readable
// [RULE13] Three sensitivity levels held and readable
// [RULE14] Sensitivity write rejected before line configured
// [RULE15] Lower sensitivity resists noise more
// [RULE16] Per-line channel set, channels may share
// [RULE17] Edge or level detection per trigger type
// [RULE18] Either-edge type forces response to output-off
// [RULE19] Lines synchronised before detection
// [RULE20] Sensitivity is stable-sample filter length
module eti_trigger_input (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [4:0]  trig_line_i,
  output logic      [3:0]  ch_output_on_o,
  output logic      [3:0]  ch_load_mode_o,
  output logic      [7:0]  ch_load_kind_o,
  output logic      [1:0]  pair_mode_o
);
  localparam int NL = eti_pkg::NUM_LINES;
  localparam int NC = eti_pkg::NUM_CH;

  logic [NL-1:0] enable_q;
  logic [3:0]    resp_q [NL];
  logic [2:0]    type_q [NL];
  logic [1:0]    sens_q [NL];
  logic [3:0]    chan_q [NL];
  logic [NL-1:0] cfg_set_q;
  logic [2:0]    sel_q;
  logic          reject_q;
  logic          ack_q;

  logic [NL-1:0] sync1_q, sync2_q, filt_q, filt_prev_q;
  logic [7:0]    cnt_q [NL];
  logic [NL-1:0] fire;

  logic          bus_req;
  logic          wr_go;
  logic          sel_ok;
  logic [3:0]    wr_resp;
  logic [2:0]    wr_type;
  logic [1:0]    wr_sens;

  // One wait state per access keeps the readback registered
  assign bus_req           = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack_q;
  // A write lands only at the edge where waitrequest is sampled low
  assign wr_go             = avs_write_i & ack_q;
  assign sel_ok            = sel_q < 3'(NL);
  assign wr_resp = avs_writedata_i[eti_pkg::CFG_RESP_LSB +: 4];
  assign wr_type = avs_writedata_i[eti_pkg::CFG_TYPE_LSB +: 3];
  assign wr_sens = avs_writedata_i[eti_pkg::CFG_SENS_LSB +: 2];

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_q <= '0;
      sel_q    <= 3'h0;
    end else if (wr_go) begin
      if (avs_address_i == eti_pkg::OFF_ENABLE) begin
        enable_q <= avs_writedata_i[NL-1:0]; // [RULE1]
      end
      if (avs_address_i == eti_pkg::OFF_LINE_SEL) begin
        sel_q <= avs_writedata_i[2:0];
      end
    end
  end

  // Line configuration; sensitivity write checked against configured flag
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NL; i++) begin
        resp_q[i] <= eti_pkg::ETI_RESP_ON;
        type_q[i] <= eti_pkg::ETI_TYPE_RISE;
        sens_q[i] <= eti_pkg::ETI_SENS_MID;
        chan_q[i] <= eti_pkg::RST_CHAN;
      end
      cfg_set_q <= '0;
      reject_q  <= 1'b0;
    end else if (wr_go && avs_address_i == eti_pkg::OFF_LINE_CFG && sel_ok) begin
      chan_q[sel_q] <= avs_writedata_i[eti_pkg::CFG_CHAN_LSB +: 4]; // [RULE16]
      if (wr_type <= 3'(eti_pkg::ETI_TYPE_BOTH)) begin
        type_q[sel_q] <= wr_type; // [RULE17]
      end
      if (wr_type == eti_pkg::ETI_TYPE_BOTH) begin
        resp_q[sel_q] <= eti_pkg::ETI_RESP_OFF; // [RULE18]
      end else if (wr_resp <= 4'(eti_pkg::parallel_tracking_action)) begin
        resp_q[sel_q] <= wr_resp; // [RULE3]
      end
      cfg_set_q[sel_q] <= 1'b1;
      if (avs_writedata_i[eti_pkg::CFG_SET_BIT]) begin
        if (cfg_set_q[sel_q] && wr_sens <= 2'(eti_pkg::ETI_SENS_HIGH)) begin
          sens_q[sel_q] <= wr_sens; // [RULE13]
          reject_q      <= 1'b0;
        end else begin
          reject_q <= 1'b1; // [RULE14]
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      avs_readdata_o <= 32'h0000_0000;
      case (avs_address_i)
        eti_pkg::OFF_ENABLE: begin
          avs_readdata_o[NL-1:0] <= enable_q; // [RULE2]
        end
        eti_pkg::OFF_STATUS: begin
          avs_readdata_o[eti_pkg::STAT_REJ_BIT] <= reject_q;
          avs_readdata_o[8 +: NL]               <= filt_q;
        end
        eti_pkg::OFF_LINE_SEL: begin
          avs_readdata_o[2:0] <= sel_q;
        end
        eti_pkg::OFF_LINE_CFG: begin
          if (sel_ok) begin
            avs_readdata_o[eti_pkg::CFG_RESP_LSB +: 4] <= resp_q[sel_q]; // [RULE12]
            avs_readdata_o[eti_pkg::CFG_TYPE_LSB +: 3] <= type_q[sel_q];
            avs_readdata_o[eti_pkg::CFG_SENS_LSB +: 2] <= sens_q[sel_q]; // [RULE13]
            avs_readdata_o[eti_pkg::CFG_CHAN_LSB +: 4] <= chan_q[sel_q];
            avs_readdata_o[eti_pkg::CFG_SET_BIT]       <= cfg_set_q[sel_q];
          end
        end
        default: begin
          avs_readdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= trig_line_i; // [RULE19]
      sync2_q <= sync1_q;
    end
  end

  // Filter: a new level is accepted only after it stood stable long enough
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      filt_q      <= '0;
      filt_prev_q <= '0;
      for (int i = 0; i < NL; i++) begin
        cnt_q[i] <= 8'h00;
      end
    end else begin
      filt_prev_q <= filt_q;
      for (int i = 0; i < NL; i++) begin
        if (sync2_q[i] == filt_q[i]) begin
          cnt_q[i] <= 8'h00;
        end else if (cnt_q[i] + 8'h01 >= (sens_q[i] == eti_pkg::ETI_SENS_LOW  ? eti_pkg::FILT_LOW :
                                          sens_q[i] == eti_pkg::ETI_SENS_HIGH ? eti_pkg::FILT_HIGH :
                                          eti_pkg::FILT_MID)) begin
          filt_q[i] <= sync2_q[i]; // [RULE20] [RULE15]
          cnt_q[i]  <= 8'h00;
        end else begin
          cnt_q[i] <= cnt_q[i] + 8'h01;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NL; i++) begin
      case (type_q[i])
        eti_pkg::ETI_TYPE_RISE: fire[i] = filt_q[i] & ~filt_prev_q[i];
        eti_pkg::ETI_TYPE_FALL: fire[i] = ~filt_q[i] & filt_prev_q[i];
        eti_pkg::ETI_TYPE_HIGH: fire[i] = filt_q[i];
        eti_pkg::ETI_TYPE_LOW:  fire[i] = ~filt_q[i];
        eti_pkg::ETI_TYPE_BOTH: fire[i] = filt_q[i] ^ filt_prev_q[i];
        default:                fire[i] = 1'b0;
      endcase
      fire[i] = fire[i] & enable_q[i]; // [RULE17] [RULE1]
    end
  end

  // Lines apply in index order; a higher line wins on the same channel
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ch_output_on_o <= 4'h0;
      ch_load_mode_o <= 4'h0;
      ch_load_kind_o <= 8'h00;
      pair_mode_o    <= eti_pkg::PAIR_IND;
    end else begin
      for (int i = 0; i < NL; i++) begin
        if (fire[i]) begin
          for (int c = 0; c < NC; c++) begin
            if (chan_q[i][c]) begin
              case (resp_q[i])
                eti_pkg::ETI_RESP_ON:     ch_output_on_o[c] <= 1'b1; // [RULE4]
                eti_pkg::ETI_RESP_OFF:    ch_output_on_o[c] <= 1'b0; // [RULE4]
                eti_pkg::ETI_RESP_TOGGLE: ch_output_on_o[c] <= ~ch_output_on_o[c]; // [RULE5]
                eti_pkg::ETI_RESP_POWER:  ch_load_mode_o[c] <= eti_pkg::MODE_SUPPLY[0]; // [RULE6]
                eti_pkg::ETI_RESP_CV: begin
                  ch_load_mode_o[c]       <= eti_pkg::MODE_LOAD[0]; // [RULE7]
                  ch_load_kind_o[2*c +: 2] <= eti_pkg::LOAD_CV;
                end
                eti_pkg::ETI_RESP_CC: begin
                  ch_load_mode_o[c]       <= eti_pkg::MODE_LOAD[0]; // [RULE7]
                  ch_load_kind_o[2*c +: 2] <= eti_pkg::LOAD_CC;
                end
                eti_pkg::const_resistance_load_action: begin
                  ch_load_mode_o[c]       <= eti_pkg::MODE_LOAD[0]; // [RULE7]
                  ch_load_kind_o[2*c +: 2] <= eti_pkg::LOAD_CR;
                end
                default: begin
                end
              endcase
            end
          end
          // Series and parallel actions rely on the controller having both channels in supply mode; independent sets supply itself
          case (resp_q[i])
            eti_pkg::independent_pair_action: begin
              pair_mode_o          <= eti_pkg::PAIR_IND; // [RULE8] [RULE11]
              ch_load_mode_o[1:0]  <= {2{eti_pkg::MODE_SUPPLY[0]}};
            end
            eti_pkg::series_tracking_action:   pair_mode_o <= eti_pkg::PAIR_SER; // [RULE9]
            eti_pkg::parallel_tracking_action: pair_mode_o <= eti_pkg::PAIR_PAR; // [RULE10]
            default: begin
            end
          endcase
        end
      end
    end
  end
endmodule

// ==== core/eti_pkg.sv ====
package eti_pkg;
  localparam int NUM_LINES = 5;
  localparam int NUM_CH    = 4;
  localparam int ADDR_W    = 4;

  // Register offsets (byte addresses, one word per register; all lines share the config word via OFF_LINE_SEL)
  localparam logic [ADDR_W-1:0] OFF_ENABLE   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_LINE_SEL = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_LINE_CFG = 4'hC;

  // Line configuration word layout
  localparam int CFG_RESP_LSB = 0;
  localparam int CFG_TYPE_LSB = 4;
  localparam int CFG_SENS_LSB = 8;
  localparam int CFG_CHAN_LSB = 12;
  localparam int CFG_SET_BIT  = 16;
  localparam int STAT_REJ_BIT = 0;

  // Filter stable-sample counts per sensitivity
  localparam logic [7:0] FILT_LOW  = 8'h40;
  localparam logic [7:0] FILT_MID  = 8'h10;
  localparam logic [7:0] FILT_HIGH = 8'h02;

  typedef enum logic [3:0] {
    ETI_RESP_ON     = 4'h0,
    ETI_RESP_OFF    = 4'h1,
    ETI_RESP_TOGGLE = 4'h2,
    ETI_RESP_POWER  = 4'h3,
    ETI_RESP_CV     = 4'h4,
    ETI_RESP_CC     = 4'h5,
    const_resistance_load_action = 4'h6,
    independent_pair_action      = 4'h7,
    series_tracking_action       = 4'h8,
    parallel_tracking_action     = 4'h9
  } eti_resp_t;

  typedef enum logic [2:0] {
    ETI_TYPE_RISE = 3'h0,
    ETI_TYPE_FALL = 3'h1,
    ETI_TYPE_HIGH = 3'h2,
    ETI_TYPE_LOW  = 3'h3,
    ETI_TYPE_BOTH = 3'h4
  } eti_type_t;

  typedef enum logic [1:0] {
    ETI_SENS_LOW  = 2'h0,
    ETI_SENS_MID  = 2'h1,
    ETI_SENS_HIGH = 2'h2
  } eti_sens_t;

  // Channel mode codes
  localparam logic [1:0] MODE_SUPPLY = 2'h0;
  localparam logic [1:0] MODE_LOAD   = 2'h1;
  localparam logic [1:0] LOAD_CV     = 2'h0;
  localparam logic [1:0] LOAD_CC     = 2'h1;
  localparam logic [1:0] LOAD_CR     = 2'h2;
  localparam logic [1:0] PAIR_IND    = 2'h0;
  localparam logic [1:0] PAIR_SER    = 2'h1;
  localparam logic [1:0] PAIR_PAR    = 2'h2;
  localparam logic [3:0] RST_CHAN    = 4'h0;
endpackage

// ==== test/eti_src.sv ====
`timescale 1ns/1ps
module eti_src (
  input  wire logic       clk_sys_i,
  input  wire logic [4:0] level_i,
  output logic      [4:0] trig_line_o
);
  // Level launched by non-blocking assignment on the rising edge, so the synchroniser
  // never sees a change inside the edge's own time step
  always_ff @(posedge clk_sys_i) begin
    trig_line_o <= level_i;
  end
endmodule

// ==== test/eti_chk_asserts.sv ====
`timescale 1ns/1ps
module eti_chk (
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [3:0]  ch_output_on_o,
  input wire logic [3:0]  ch_load_mode_o,
  input wire logic [7:0]  ch_load_kind_o,
  input wire logic [1:0]  pair_mode_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire req = avs_read_i | avs_write_i;
  sequence s_new_req;
    req && !$past(req);
  endsequence
  sequence s_stall;
    req && avs_waitrequest_o;
  endsequence
  AST_WAIT_FIRST: assert property (s_new_req |-> avs_waitrequest_o)
    else $error("new access not stalled");
  AST_WAIT_ONE: assert property (s_stall |=> !avs_waitrequest_o)
    else $error("more than one wait state");
  AST_WAIT_IDLE: assert property (!req |-> !avs_waitrequest_o)
    else $error("stall while idle");
  AST_READ_HOLD: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i[1:0] != 2'h0 |=> avs_readdata_o == 32'h0) else $error("unmapped read not 0");
  AST_RESET_OUT: assert property ($rose(reset_n_i) |->
    {ch_output_on_o, ch_load_mode_o, ch_load_kind_o, pair_mode_o} == 18'h0)
    else $error("outputs not cleared by reset");
  AST_PAIR_CODE: assert property (pair_mode_o != 2'h3)
    else $error("bad pairing code");
  AST_KIND_CODE: assert property (ch_load_kind_o[1:0] != 2'h3 &&
    ch_load_kind_o[3:2] != 2'h3 && ch_load_kind_o[5:4] != 2'h3 && ch_load_kind_o[7:6] != 2'h3)
    else $error("bad load kind");
  AST_IND_SUPPLY: assert property ($changed(pair_mode_o) && pair_mode_o == 2'h0 |->
    ch_load_mode_o[1:0] == 2'h0) else $error("independent pairing left a channel in load mode");
endmodule
bind eti_trigger_input eti_chk u_chk (.clk_sys_i, .reset_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .ch_output_on_o, .ch_load_mode_o,
  .ch_load_kind_o, .pair_mode_o);

// ==== test/eti_trigger_input_bench.sv ====
`timescale 1ns/1ps
module eti_trigger_input_bench;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [4:0]  lvl_q = 5'h00;
  logic [4:0]  trig_line_i;
  logic [3:0]  ch_output_on_o;
  logic [3:0]  ch_load_mode_o;
  logic [7:0]  ch_load_kind_o;
  logic [1:0]  pair_mode_o;
  logic [31:0] rd_q;
  logic [17:0] e_q = 18'h0;
  int          n_mismatch = 0;
  int          compares = 0;
  int          codes[10] = '{0, 1, 2, 4, 5, 6, 3, 8, 9, 7};
  always #25 clk_sys_i = ~clk_sys_i;
  eti_src u_src (.clk_sys_i(clk_sys_i), .level_i(lvl_q), .trig_line_o(trig_line_i));
  eti_trigger_input DUT (.clk_sys_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .trig_line_i, .ch_output_on_o,
    .ch_load_mode_o, .ch_load_kind_o, .pair_mode_o);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // Right after the edge the design's own updates have not landed yet: this is what it sampled
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_sys_i);
    end
    rd_q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd_q & m);
  endtask
  task automatic cfg(input logic [2:0] ln, input logic [31:0] w);
    bus(1'b1, eti_pkg::OFF_LINE_SEL, {29'h0, ln});
    bus(1'b1, eti_pkg::OFF_LINE_CFG, w);
  endtask
  task automatic trig(input logic lv, input int n);
    lvl_q[0] <= lv;
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic outs(input string nm);
    chk(nm, {14'h0, e_q}, {14'h0, pair_mode_o, ch_load_kind_o, ch_load_mode_o, ch_output_on_o});
  endtask
  task automatic t_defaults;
    outs("reset outputs");
    rchk("enable", eti_pkg::OFF_ENABLE, 32'h1F, 32'h0);
    rchk("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, eti_pkg::OFF_LINE_SEL, 32'h0);
    rchk("line cfg", eti_pkg::OFF_LINE_CFG, 32'hFFFF, 32'h100);
    $display("test defaults done");
  endtask
  task automatic t_sens;
    cfg(3'h1, 32'h10200);
    rchk("reject", eti_pkg::OFF_STATUS, 32'h1, 32'h1);
    rchk("sens kept", eti_pkg::OFF_LINE_CFG, 32'h300, 32'h100);
    for (int s = 0; s < 3; s++) begin
      cfg(3'h1, 32'h10000 | (s << 8));
      rchk("sens", eti_pkg::OFF_LINE_CFG, 32'h300, s << 8);
    end
    rchk("reject clear", eti_pkg::OFF_STATUS, 32'h1, 32'h0);
    $display("test sensitivity done");
  endtask
  task automatic t_resp;
    cfg(3'h0, 32'h1000);
    cfg(3'h0, 32'h11200);
    trig(1'b1, 15);
    trig(1'b0, 15);
    outs("disabled line");
    bus(1'b1, eti_pkg::OFF_ENABLE, 32'h1);
    rchk("enable on", eti_pkg::OFF_ENABLE, 32'h1F, 32'h1);
    // Pairing codes last and after supply, so the controller keeps its side of the pair
    foreach (codes[i]) begin
      cfg(3'h0, 32'h13200 | codes[i]);
      rchk("response", eti_pkg::OFF_LINE_CFG, 32'hF00F, 32'h3000 | codes[i]);
      case (codes[i])
        0: e_q[1:0] = 2'h3;
        1: e_q[1:0] = 2'h0;
        2: e_q[1:0] = ~e_q[1:0];
        3: e_q[5:4] = 2'h0;
        4, 5, 6: begin
          e_q[5:4] = 2'h3;
          e_q[11:8] = {2{2'(codes[i] - 4)}};
        end
        default: e_q[17:16] = 2'(codes[i] - 7);
      endcase
      if (codes[i] == 7) e_q[5:4] = 2'h0;
      trig(1'b1, 15);
      outs("response action");
      trig(1'b0, 15);
      outs("no fire on fall");
    end
    $display("test responses done");
  endtask
  task automatic t_types;
    cfg(3'h0, 32'h13212);
    trig(1'b1, 15);
    outs("fall ignores rise");
    trig(1'b0, 15);
    e_q[1:0] = ~e_q[1:0];
    outs("fall fires");
    cfg(3'h0, 32'h13002);
    trig(1'b1, 30);
    trig(1'b0, 80);
    outs("short pulse filtered");
    trig(1'b1, 90);
    e_q[1:0] = ~e_q[1:0];
    outs("long pulse passes");
    cfg(3'h0, 32'h13231);
    outs("low level idle while high");
    trig(1'b0, 15);
    e_q[1:0] = 2'h0;
    outs("low level fires off");
    cfg(3'h0, 32'h13220);
    outs("high level idle while low");
    trig(1'b1, 15);
    e_q[1:0] = 2'h3;
    outs("high level fires on");
    cfg(3'h0, 32'h13240);
    rchk("either forces off", eti_pkg::OFF_LINE_CFG, 32'h7F, 32'h41);
    trig(1'b0, 15);
    e_q[1:0] = 2'h0;
    outs("either edge off");
    $display("test trigger types done");
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_defaults();
    t_sens();
    t_resp();
    t_types();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    results();
  end
endmodule
